//--- core/dog_pkg.sv
// constants, register map and decode helpers for the watchdog and reset control
package dog_pkg;

	// clock and documented times, in nanoseconds
	localparam int CLK_PERIOD_NS      = 50;
	localparam int POR_DELAY_NS       = 50_000_000;
	localparam int WARM_DELAY_NS      = 16_700_000;
	localparam int KEY_FAULT_DELAY_NS = 10_000;
	localparam int FILTER_TIME_NS     = 100_000;

	// typical delays divide plainly, least times round up
	localparam int POR_CYCLES       = POR_DELAY_NS / CLK_PERIOD_NS;
	localparam int WARM_CYCLES      = WARM_DELAY_NS / CLK_PERIOD_NS;
	localparam int KEY_FAULT_CYCLES = (KEY_FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_CYCLES    = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// counter widths
	localparam int HOLD_W  = 20;
	localparam int FAULT_W = 12;
	localparam int CNT_W   = 18;

	// register offsets
	localparam logic [1:0] OFF_DOG    = 2'h0;
	localparam logic [1:0] OFF_LEVEL  = 2'h1;
	localparam logic [1:0] OFF_FLAGS  = 2'h2;
	localparam logic [1:0] OFF_STATUS = 2'h3;

	// field positions
	localparam int KEY_LSB        = 3;
	localparam int FLAG_KEY_BIT   = 0;
	localparam int FLAG_LEVEL_BIT = 1;
	localparam int FLAG_BROWN_BIT = 2;
	localparam int STAT_PD_BIT    = 4;
	localparam int STAT_TO_BIT    = 5;

	// reset values and valid codes
	localparam logic [7:0] DOG_CTRL_RESET = 8'h53;
	localparam logic [7:0] LEVEL_RESET    = 8'h55;
	localparam logic [4:0] KEY_A          = 5'h0a;
	localparam logic [4:0] KEY_B          = 5'h15;
	localparam logic [7:0] LEVEL_A        = 8'h55;
	localparam logic [7:0] LEVEL_B        = 8'h33;
	localparam logic [7:0] LEVEL_C        = 8'h99;
	localparam logic [7:0] LEVEL_D        = 8'haa;

	function automatic logic key_valid(input logic [4:0] key);
		return (key == KEY_A) || (key == KEY_B);
	endfunction : key_valid

	function automatic logic level_valid(input logic [7:0] code);
		return (code == LEVEL_A) || (code == LEVEL_B) || (code == LEVEL_C) || (code == LEVEL_D);
	endfunction : level_valid

	// last count before overflow for each select code
	function automatic logic [CNT_W-1:0] timeout_last(input logic [2:0] sel);
		case (sel)
			3'h0:    return 18'h0_00ff;
			3'h1:    return 18'h0_03ff;
			3'h2:    return 18'h0_0fff;
			3'h3:    return 18'h0_3fff;
			3'h4:    return 18'h0_7fff;
			3'h5:    return 18'h0_ffff;
			3'h6:    return 18'h1_ffff;
			default: return 18'h3_ffff;
		endcase
	endfunction : timeout_last

endpackage : dog_pkg

//--- core/dog_link_if.sv
// link between the reset control and the watchdog counter
interface dog_link_if;
	logic       tick;
	logic       clear;
	logic       enable;
	logic [2:0] select;
	logic       overflow;

	modport counter (input tick, input clear, input enable, input select, output overflow);
	modport control (output tick, output clear, output enable, output select, input overflow);
endinterface : dog_link_if

//--- core/dog_counter.sv
// watchdog counter clocked by slow-clock ticks
module dog_counter (
	input wire logic         clk,
	input wire logic         rst,
	dog_link_if.counter      link
);

	typedef struct packed {
		logic [dog_pkg::CNT_W-1:0] count;
		logic                      overflow;
	} cnt_state_t;

	cnt_state_t state;
	cnt_state_t next_state;

	// count ticks, wrap and flag on the selected last count
	always_comb begin
		next_state = state;
		next_state.overflow = 1'h0;
		if (link.clear || !link.enable) begin
			next_state.count = '0;
		end else if (link.tick) begin
			// >= so that shortening the period mid-count still times out
			if (state.count >= dog_pkg::timeout_last(link.select)) begin
				next_state.count = '0;
				next_state.overflow = 1'h1;
			end else begin
				next_state.count = state.count + 18'h0_0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign link.overflow = state.overflow;

	overflow_cause_a: assert property (@(posedge clk) disable iff (rst)
		link.overflow |-> $past(link.tick) && $past(link.enable) && !$past(link.clear))
		else $error("overflow without an enabled tick");

	clear_zero_a: assert property (@(posedge clk) disable iff (rst)
		(link.clear || !link.enable) |=> (state.count == '0) && !link.overflow)
		else $error("counter not cleared");

endmodule : dog_counter

//--- core/dog_reset_ctrl.sv
// watchdog timer with reset-source control, brown-out filter and reset flags
// Notes on behaviour
// - counter overflow without a clear resets the device
// - watchdog counts only while the enable key is 01010 or 10101
// - any other key value resets the device after the key-fault delay
// - after power-on the enable key holds 01010, watchdog enabled
// - time-out in normal running gives a full reset and sets the time-out flag
// - time-out in sleep sets the time-out flag and clears only PC and stack pointer
// - counter clears on invalid key, clear instruction or halt instruction
// - time-out period spans slow clock divided by 2^8 up to 2^18
// - power-on reset sets the program counter to zero
// - power-on reset sets all port data and direction bits to one
// - power-on holds reset for about 50 ms before the first instruction
// - brown-out resets only when low supply outlasts the filter, sets its flag
// - brown-out detection is off in sleep or idle; here only SLEEPING turns it off, there is no idle input
// - level register accepts four codes, others reset after delay and flag
// - genuine brown-out leaves the level register unchanged
// - reset from a bad level code reloads the level default 01010101
// - brown-out flag set by hardware, cleared only by software writing zero
// - level fault flag set on undefined code, cleared only by writing zero
// - normal time-out reset acts like brown-out plus the time-out flag; here brown-out holds about 50 ms, time-out about 16.7 ms
// - normal time-out reset holds reset for about 16.7 ms
// - three-bit select picks 2^8,10,12,14,15,16,17,18
// - key fault flag set on invalid-key reset, cleared only by writing zero
// - halt instruction sets the power-down flag
module dog_reset_ctrl #(
	parameter int POR_CYCLES  = dog_pkg::POR_CYCLES,
	parameter int WARM_CYCLES = dog_pkg::WARM_CYCLES
) (
	input  wire logic       CLOCK,
	input  wire logic       RESET,
	input  wire logic       SLOW_CLOCK,
	input  wire logic       LOW_SUPPLY,
	input  wire logic       SLEEPING,
	input  wire logic       CLEAR_DOG,
	input  wire logic       HALT,
	input  wire logic [1:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	output logic            CPU_RESET,
	output logic            PC_SP_CLEAR,
	output logic            PORT_PRESET
);

	typedef enum logic [0:0] {
		PH_HOLD,
		PH_RUN
	} phase_t;

	typedef struct packed {
		logic [2:0]                  slow_sync;
		logic                        slow_level;
		logic [2:0]                  low_sync;
		logic                        low_level;
		phase_t                      phase;
		logic [dog_pkg::HOLD_W-1:0]  hold_cnt;
		logic [dog_pkg::FAULT_W-1:0] fault_cnt;
		logic [dog_pkg::FAULT_W-1:0] filt_cnt;
		logic [7:0]                  dog_ctrl;
		logic [7:0]                  level;
		logic                        key_fault;
		logic                        level_fault;
		logic                        brown_flag;
		logic                        to_flag;
		logic                        pd_flag;
		logic [7:0]                  rdata;
		logic                        cpu_reset;
		logic                        pc_sp_clear;
		logic                        port_preset;
	} ctrl_state_t;

	localparam logic [dog_pkg::HOLD_W-1:0] POR_LOAD =
		dog_pkg::HOLD_W'(POR_CYCLES - 1);
	localparam logic [dog_pkg::HOLD_W-1:0] WARM_LOAD =
		dog_pkg::HOLD_W'(WARM_CYCLES - 1);
	localparam logic [dog_pkg::FAULT_W-1:0] FAULT_LAST =
		dog_pkg::FAULT_W'(dog_pkg::KEY_FAULT_CYCLES - 1);
	localparam logic [dog_pkg::FAULT_W-1:0] FILTER_FULL =
		dog_pkg::FAULT_W'(dog_pkg::FILTER_CYCLES);

	ctrl_state_t state;
	ctrl_state_t next_state;
	dog_link_if  link ();

	logic key_ok;
	logic level_ok;
	logic slow_rise;
	logic brown_trip;
	logic fault_trip;
	logic running;
	logic flag_wr;

	// decoded conditions shared by the update logic and the checks
	assign key_ok     = dog_pkg::key_valid(state.dog_ctrl[7:dog_pkg::KEY_LSB]);
	assign level_ok   = dog_pkg::level_valid(state.level);
	assign running    = (state.phase == PH_RUN);
	// slow edge counts only once the second and third stages agree
	assign slow_rise  = (state.slow_sync[1] == state.slow_sync[2]) && state.slow_sync[2]
		&& !state.slow_level;
	// filter saturates so a persisting low supply keeps the device held
	assign brown_trip = state.low_level && !SLEEPING && (state.filt_cnt == FILTER_FULL);
	assign fault_trip = running && !(key_ok && level_ok) && (state.fault_cnt == FAULT_LAST);
	// the only path that may lower the key, level or brown-out flag
	assign flag_wr    = running && WR && (ADDR == dog_pkg::OFF_FLAGS);

	// counter steering; hold and instructions clear it
	assign link.tick   = slow_rise;
	assign link.clear  = !running || CLEAR_DOG || HALT;
	assign link.enable = key_ok;
	assign link.select = state.dog_ctrl[2:0];

	dog_counter counter (
		.clk  (CLOCK),
		.rst  (RESET),
		.link (link)
	);

	// whole next-state function of the control
	always_comb begin
		logic sleep_hit;
		sleep_hit = 1'h0;
		next_state = state;
		next_state.rdata = 8'h00;

		// three-stage pin synchronisers
		next_state.slow_sync = {state.slow_sync[1:0], SLOW_CLOCK};
		next_state.low_sync  = {state.low_sync[1:0], LOW_SUPPLY};
		if (state.slow_sync[1] == state.slow_sync[2]) begin
			next_state.slow_level = state.slow_sync[2];
		end
		if (state.low_sync[1] == state.low_sync[2]) begin
			next_state.low_level = state.low_sync[2];
		end

		// brown-out filter, idle while asleep
		if (state.low_level && !SLEEPING) begin
			if (state.filt_cnt != FILTER_FULL) begin
				next_state.filt_cnt = state.filt_cnt + 12'h001;
			end
		end else begin
			next_state.filt_cnt = '0;
		end

		// key or level fault delay
		if (running && !(key_ok && level_ok)) begin
			next_state.fault_cnt = state.fault_cnt + 12'h001;
		end else begin
			next_state.fault_cnt = '0;
		end

		// register reads answer in the next cycle only
		if (RD) begin
			case (ADDR)
				dog_pkg::OFF_DOG:   next_state.rdata = state.dog_ctrl;
				dog_pkg::OFF_LEVEL: next_state.rdata = state.level;
				dog_pkg::OFF_FLAGS: begin
					next_state.rdata[dog_pkg::FLAG_KEY_BIT]   = state.key_fault;
					next_state.rdata[dog_pkg::FLAG_LEVEL_BIT] = state.level_fault;
					next_state.rdata[dog_pkg::FLAG_BROWN_BIT] = state.brown_flag;
				end
				default: begin
					next_state.rdata[dog_pkg::STAT_PD_BIT] = state.pd_flag;
					next_state.rdata[dog_pkg::STAT_TO_BIT] = state.to_flag;
				end
			endcase
		end

		case (state.phase)
			PH_HOLD: begin
				if (state.hold_cnt == '0) begin
					next_state.phase = PH_RUN;
				end else begin
					next_state.hold_cnt = state.hold_cnt - 20'h0_0001;
				end
			end
			PH_RUN: begin
				// writes first, so that hardware sets below win the same cycle
				if (WR) begin
					case (ADDR)
						dog_pkg::OFF_DOG:   next_state.dog_ctrl = WDATA;
						dog_pkg::OFF_LEVEL: next_state.level = WDATA;
						dog_pkg::OFF_FLAGS: begin
							// a one leaves the flag, a zero clears it
							next_state.key_fault   = state.key_fault
								& WDATA[dog_pkg::FLAG_KEY_BIT];
							next_state.level_fault = state.level_fault
								& WDATA[dog_pkg::FLAG_LEVEL_BIT];
							next_state.brown_flag  = state.brown_flag
								& WDATA[dog_pkg::FLAG_BROWN_BIT];
						end
						default: ;
					endcase
				end
				// instruction effects on the status bits
				if (CLEAR_DOG) begin
					next_state.to_flag = 1'h0;
					next_state.pd_flag = 1'h0;
				end
				if (HALT) begin
					next_state.pd_flag = 1'h1;
				end
				if (fault_trip) begin
					// a software clear in the same cycle survives unless that flag's own key or level code is bad
					if (!key_ok) begin
						next_state.key_fault = 1'h1;
					end
					if (!level_ok) begin
						next_state.level_fault = 1'h1;
						next_state.level = dog_pkg::LEVEL_RESET;
					end
					next_state.dog_ctrl = dog_pkg::DOG_CTRL_RESET;
					next_state.hold_cnt = POR_LOAD;
					next_state.phase = PH_HOLD;
				end else if (link.overflow && SLEEPING) begin
					// warm wake: only PC and stack pointer, rest untouched
					next_state.to_flag = 1'h1;
					sleep_hit = 1'h1;
				end else if (link.overflow) begin
					next_state.to_flag = 1'h1;
					next_state.dog_ctrl = dog_pkg::DOG_CTRL_RESET;
					next_state.hold_cnt = WARM_LOAD;
					next_state.phase = PH_HOLD;
				end
			end
			default: begin
				next_state.phase = PH_HOLD;
			end
		endcase

		// brown-out outranks everything and may strike in any phase
		if (brown_trip) begin
			next_state.brown_flag = 1'h1;
			next_state.dog_ctrl = dog_pkg::DOG_CTRL_RESET;
			next_state.hold_cnt = POR_LOAD;
			next_state.phase = PH_HOLD;
			next_state.to_flag = state.to_flag;
			sleep_hit = 1'h0;
		end

		// registered reset outputs follow the next phase
		next_state.cpu_reset   = (next_state.phase == PH_HOLD);
		next_state.port_preset = (next_state.phase == PH_HOLD);
		next_state.pc_sp_clear = (next_state.phase == PH_HOLD) || sleep_hit;
	end

	// power-on state; counts restart from the full release delay
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state             <= '0;
			state.phase       <= PH_HOLD;
			state.hold_cnt    <= POR_LOAD;
			state.dog_ctrl    <= dog_pkg::DOG_CTRL_RESET;
			state.level       <= dog_pkg::LEVEL_RESET;
			state.cpu_reset   <= 1'h1;
			state.port_preset <= 1'h1;
			state.pc_sp_clear <= 1'h1;
		end else begin
			state <= next_state;
		end
	end

	assign RDATA       = state.rdata;
	assign CPU_RESET   = state.cpu_reset;
	assign PC_SP_CLEAR = state.pc_sp_clear;
	assign PORT_PRESET = state.port_preset;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	// running with no competing reset cause this cycle
	sequence quiet_run;
		running && !brown_trip && !fault_trip;
	endsequence

	sequence awake_overflow;
		quiet_run and (link.overflow && !SLEEPING);
	endsequence

	sequence asleep_overflow;
		quiet_run and (link.overflow && SLEEPING);
	endsequence

	por_hold_a: assert property ($fell(RESET) |-> CPU_RESET && PORT_PRESET
		&& PC_SP_CLEAR && (state.dog_ctrl == dog_pkg::DOG_CTRL_RESET))
		else $error("power-on reset not held");

	awake_timeout_a: assert property (awake_overflow |=> CPU_RESET && state.to_flag
		&& (state.hold_cnt == WARM_LOAD))
		else $error("normal time-out did not reset");

	sleep_timeout_a: assert property (asleep_overflow |=> PC_SP_CLEAR && !CPU_RESET
		&& state.to_flag ##1 !PC_SP_CLEAR)
		else $error("sleep time-out misbehaved");

	key_fault_a: assert property (fault_trip && !key_ok
		|=> CPU_RESET && state.key_fault)
		else $error("bad key did not reset");

	brown_trip_a: assert property (brown_trip |=> CPU_RESET && state.brown_flag
		&& (state.level == $past(state.level)))
		else $error("brown-out reset wrong");

	brown_sleep_a: assert property (SLEEPING |=> state.filt_cnt == '0)
		else $error("brown-out filter ran in sleep");

	level_reload_a: assert property (fault_trip && !level_ok
		|=> state.level == dog_pkg::LEVEL_RESET && state.level_fault)
		else $error("bad level code not reloaded");

	flag_write_a: assert property (quiet_run and (WR && ADDR == dog_pkg::OFF_FLAGS
		&& !state.brown_flag) |=> !state.brown_flag)
		else $error("software write set a flag");

	halt_pd_a: assert property (quiet_run and (HALT && !CLEAR_DOG)
		|=> state.pd_flag)
		else $error("halt did not set power-down flag");

	read_once_a: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data outside answer cycle");

	brown_sticky_a: assert property (state.brown_flag && !flag_wr |=> state.brown_flag)
		else $error("brown-out flag lost without a write");

	level_sticky_a: assert property (state.level_fault && !flag_wr |=> state.level_fault)
		else $error("level fault flag lost without a write");

	key_sticky_a: assert property (state.key_fault && !flag_wr |=> state.key_fault)
		else $error("key fault flag lost without a write");

	level_write_a: assert property (quiet_run and (WR && ADDR == dog_pkg::OFF_LEVEL)
		|=> state.level == $past(WDATA))
		else $error("level write not taken");

	hold_frozen_a: assert property (!running && !brown_trip
		|=> state.dog_ctrl == $past(state.dog_ctrl) && state.level == $past(state.level))
		else $error("register changed during reset hold");

endmodule : dog_reset_ctrl

//--- tb/core_model.sv
// processor-core model: register accesses
module core_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [1:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idle at time zero
	initial begin
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle write; data inverted afterwards so a late sample cannot pass
	task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask : write_reg

	// read data stands only in the cycle after the strobe
	task automatic read_reg(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : read_reg
endmodule : core_model

//--- tb/tb_top.sv
// self-checking bench for the watchdog and reset control
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int POR  = 20;
	localparam int WARM = 12;

	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic       slow  = 1'b0;
	logic       low   = 1'b0;
	logic       sleep = 1'b0;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       wr;
	logic       rd;
	logic       clr   = 1'b0;
	logic       halt  = 1'b0;
	logic       cpu_reset;
	logic       pc_sp;
	logic       preset;
	logic [7:0] d;
	logic       hit;
	int         n;
	int         num_errors = 0;
	int         compares = 0;

	// fast clock, and a slow tick every eight fast cycles
	always #25 clock = ~clock;
	always #200 slow = ~slow;

	dog_reset_ctrl #(.POR_CYCLES(POR), .WARM_CYCLES(WARM)) u_dog_reset_ctrl (
		.CLOCK(clock), .RESET(reset), .SLOW_CLOCK(slow), .LOW_SUPPLY(low),
		.SLEEPING(sleep), .CLEAR_DOG(clr), .HALT(halt), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CPU_RESET(cpu_reset), .PC_SP_CLEAR(pc_sp),
		.PORT_PRESET(preset));

	core_model u_core_model (
		.clk(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	task automatic stop_test();
		if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// bounded wait for the reset output to reach a level; n counts the edges
	task automatic wait_rst(input logic v, input int bound);
		n = 0;
		while (cpu_reset !== v) begin
			@(posedge clock);
			#1 n++;
			if (n > bound) begin
				num_errors++;
				$display("[FAIL] cpu_reset expected %b seen %b", v, cpu_reset);
				stop_test();
			end
		end
	endtask : wait_rst

	// run some cycles and note whether any full reset appeared
	task automatic idle(input int cycles);
		hit = 1'b0;
		repeat (cycles) begin
			@(posedge clock);
			#1 if (cpu_reset !== 1'b0) hit = 1'b1;
		end
	endtask : idle

	task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
		u_core_model.read_reg(a, d);
		check(what, exp, d);
	endtask : rd_chk

	// single clear instruction or halt, one cycle each
	task automatic pulse(input logic is_halt);
		@(posedge clock);
		if (is_halt) begin
			halt <= 1'b1;
		end else begin
			clr <= 1'b1;
		end
		@(posedge clock);
		halt <= 1'b0;
		clr <= 1'b0;
	endtask : pulse

	task automatic s_por();
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		#1 check("reset outputs", 8'h07, {5'h0, cpu_reset, pc_sp, preset});
		wait_rst(1'b0, POR + 5);
		check("por hold", 8'h01, 8'(n >= POR && n <= POR + 2));
		rd_chk("dog ctrl", 2'h0, 8'h53);
		rd_chk("level", 2'h1, 8'h55);
		rd_chk("flags", 2'h2, 8'h00);
		rd_chk("status", 2'h3, 8'h00);
	endtask : s_por

	task automatic s_instr();
		pulse(1'b1);
		rd_chk("status halt", 2'h3, 8'h10);
		u_core_model.write_reg(2'h3, 8'hff);
		rd_chk("status ro", 2'h3, 8'h10);
		pulse(1'b0);
		rd_chk("status clear", 2'h3, 8'h00);
	endtask : s_instr

	task automatic s_timeout();
		u_core_model.write_reg(2'h0, 8'h50);
		repeat (4) begin
			pulse(1'b0);
			idle(1500);
			check("kept alive", 8'h00, 8'(hit));
		end
		pulse(1'b0);
		idle(1900);
		check("early timeout", 8'h00, 8'(hit));
		wait_rst(1'b1, 400);
		#1 check("ports preset", 8'h01, 8'(preset));
		wait_rst(1'b0, WARM + 5);
		check("warm hold", 8'h01, 8'(n >= WARM - 1 && n <= WARM + 2));
		rd_chk("status to", 2'h3, 8'h20);
		rd_chk("dog reload", 2'h0, 8'h53);
		rd_chk("flags to", 2'h2, 8'h00);
	endtask : s_timeout

	task automatic s_sleep();
		u_core_model.write_reg(2'h0, 8'h50);
		pulse(1'b0);
		sleep <= 1'b1;
		n = 0;
		while (pc_sp !== 1'b1 && n < 2400) begin
			@(posedge clock);
			#1 n++;
		end
		check("sleep pulse", 8'h01, 8'(pc_sp));
		check("sleep no reset", 8'h00, 8'(cpu_reset));
		@(posedge clock);
		#1 check("pulse width", 8'h00, 8'(pc_sp));
		sleep <= 1'b0;
		rd_chk("status sleep", 2'h3, 8'h20);
		rd_chk("dog kept", 2'h0, 8'h50);
	endtask : s_sleep

	task automatic s_select();
		u_core_model.write_reg(2'h0, 8'ha9);
		pulse(1'b0);
		idle(7900);
		check("sel1 early", 8'h00, 8'(hit));
		wait_rst(1'b1, 700);
		wait_rst(1'b0, WARM + 5);
	endtask : s_select

	task automatic s_key();
		u_core_model.write_reg(2'h0, 8'h00);
		wait_rst(1'b1, 240);
		check("key delay", 8'h01, 8'(n >= 196));
		wait_rst(1'b0, POR + 5);
		rd_chk("key flag", 2'h2, 8'h01);
		u_core_model.write_reg(2'h2, 8'hff);
		rd_chk("one keeps", 2'h2, 8'h01);
		u_core_model.write_reg(2'h2, 8'h00);
		rd_chk("zero clears", 2'h2, 8'h00);
	endtask : s_key

	task automatic s_level();
		logic [7:0] codes[4] = '{8'h55, 8'h33, 8'h99, 8'haa};
		foreach (codes[i]) begin
			u_core_model.write_reg(2'h1, codes[i]);
			rd_chk("level code", 2'h1, codes[i]);
			idle(300);
			check("valid code", 8'h00, 8'(hit));
		end
		u_core_model.write_reg(2'h1, 8'h12);
		wait_rst(1'b1, 240);
		check("level delay", 8'h01, 8'(n >= 196));
		wait_rst(1'b0, POR + 5);
		rd_chk("level default", 2'h1, 8'h55);
		rd_chk("level flag", 2'h2, 8'h02);
		u_core_model.write_reg(2'h2, 8'h00);
	endtask : s_level

	task automatic s_brown();
		u_core_model.write_reg(2'h1, 8'h33);
		low <= 1'b1;
		idle(1000);
		check("short dip", 8'h00, 8'(hit));
		low <= 1'b0;
		idle(20);
		sleep <= 1'b1;
		low <= 1'b1;
		idle(3000);
		check("asleep dip", 8'h00, 8'(hit));
		sleep <= 1'b0;
		idle(20);
		wait_rst(1'b1, 2300);
		n = n + 20; // idle(20) ran before the wait
		hit = (n > dog_pkg::FILTER_CYCLES) && (n <= dog_pkg::FILTER_CYCLES + 4);
		check("filter", 8'h01, 8'(hit));
		low <= 1'b0;
		wait_rst(1'b0, POR + 20);
		rd_chk("brown flag", 2'h2, 8'h04);
		rd_chk("level kept", 2'h1, 8'h33);
		u_core_model.write_reg(2'h2, 8'h04);
		rd_chk("brown keeps", 2'h2, 8'h04);
		u_core_model.write_reg(2'h2, 8'h00);
		rd_chk("brown clear", 2'h2, 8'h00);
	endtask : s_brown

	// main sequence
	initial begin
		s_por();
		s_instr();
		s_timeout();
		s_sleep();
		s_select();
		s_key();
		s_level();
		s_brown();
		stop_test();
	end
endmodule : tb_top
